// File: ssp_setpoint_source.sv
`default_nettype none
// Operation
// - main and supplementary setpoints each pick analog, fieldbus, pot or fixed
// - panel, jog or linked active technology controller replace main setpoint
// - code 755 index 0 routes analog input 0 to the setpoint
// - code 2050 index 1 routes the second process word
// - code 1050 makes the emulated potentiometer the setpoint
// - raise command ramps output up, lower command ramps it down
// - raising uses the rise time, default ten seconds
// - lowering uses the fall time, default ten seconds
// - motor switch-on loads the initial value unless retention is on
// - config word has five option bits, reset 00110 binary
// - bit 0 keeps output over switch-off and restores it at switch-on
// - auto mode with bit 1 clear bypasses the ramp, set applies it
// - manual mode always applies the ramp
// - bit 2 adds initial rounding for very small setpoint changes
// - bits 3 and 0 set store retained value in nonvolatile storage
// - bit 4 clear updates only with pulses enabled except switch-on and strobe loads, set always
// - ceiling and floor speeds, both reset to zero rpm
// - rising edge of load strobe loads output from load value
// - load strobe and load value sources selectable, both default zero
module ssp_setpoint_source #(
    parameter int TICK_CYCLES = ssp_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ssp_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // setpoint sources
    input wire ssp_pkg::ssp_srcs_type srcs_in,
    input wire ssp_pkg::ssp_ovr_type ovr_in,
    input wire ssp_pkg::ssp_ovr_sp_type ovr_sp_in,
    // potentiometer controls
    input wire logic pot_raise_cmd_in,
    input wire logic pot_lower_cmd_in,
    input wire logic pot_auto_manual_select_in,
    input wire logic pot_load_strobe_in,
    input wire logic signed [15:0] pot_load_value_in,
    input wire logic motor_on_in,
    input wire logic pulse_en_in,
    // nonvolatile store
    input wire logic nv_valid_in,
    input wire logic signed [15:0] nv_value_in,
    output logic nv_save_out,
    output logic signed [15:0] nv_value_out,
    // setpoints
    output logic signed [15:0] main_setpoint_out,
    output logic signed [15:0] supp_setpoint_out,
    output logic signed [15:0] pot_value_out
);
    // ***********************************************
    // functions
    // ***********************************************
    function automatic ssp_pkg::ssp_src_type src_decode(
        input ssp_pkg::ssp_sel_type s);
        if (s.code == ssp_pkg::CODE_ANALOG && s.index == ssp_pkg::IDX_ANALOG)
            return ssp_pkg::SRC_ANALOG;
        if (s.code == ssp_pkg::CODE_FIELDBUS &&
            s.index == ssp_pkg::IDX_FIELDBUS)
            return ssp_pkg::SRC_FIELDBUS;
        if (s.code == ssp_pkg::CODE_POT)
            return ssp_pkg::SRC_POT;
        if (s.code == ssp_pkg::CODE_FIXED)
            return ssp_pkg::SRC_FIXED;
        return ssp_pkg::SRC_NONE;
    endfunction

    function automatic logic signed [15:0] src_value(
        input ssp_pkg::ssp_src_type s, input ssp_pkg::ssp_srcs_type v,
        input logic signed [15:0] pot);
        unique case (s)
            ssp_pkg::SRC_ANALOG: return v.analog0;
            ssp_pkg::SRC_FIELDBUS: return v.fieldbus;
            ssp_pkg::SRC_POT: return pot;
            ssp_pkg::SRC_FIXED: return v.fixed;
            default: return 16'sh0000;
        endcase
    endfunction

    // saturate a widened value between floor and ceiling
    function automatic logic signed [15:0] clamp(
        input logic signed [16:0] v, input logic signed [15:0] lo,
        input logic signed [15:0] hi);
        logic signed [16:0] r;
        r = v;
        if (r > 17'(hi))
            r = 17'(hi);
        if (r < 17'(lo))
            r = 17'(lo);
        return r[15:0];
    endfunction

    // ***********************************************
    // register file
    // ***********************************************
    ssp_pkg::ssp_sel_type main_sel_r, main_sel_nxt;
    ssp_pkg::ssp_sel_type supp_sel_r, supp_sel_nxt;
    ssp_pkg::ssp_cfg_type cfg_r, cfg_nxt;
    logic [15:0] rise_r, rise_nxt;
    logic [15:0] fall_r, fall_nxt;
    logic signed [15:0] initial_r, initial_nxt;
    logic signed [15:0] ceil_r, ceil_nxt;
    logic signed [15:0] floor_r, floor_nxt;
    logic [1:0] load_sel_r, load_sel_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic signed [15:0] pot_r;
    logic wr_en;
    logic rd_phase;
    logic hit;
    logic [31:0] rd_word;

    // two-cycle access: pready rises one cycle into the access phase
    assign rd_phase = psel_in & penable_in & ~pready_r;
    assign wr_en = psel_in & penable_in & pready_r & pwrite_in & ~pslverr_r;

    always_comb begin
        hit = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr_in)
            ssp_pkg::OFS_MAIN_SEL: rd_word = {12'h000, main_sel_r};
            ssp_pkg::OFS_SUPP_SEL: rd_word = {12'h000, supp_sel_r};
            ssp_pkg::OFS_CONFIG: rd_word = {27'h0, cfg_r};
            ssp_pkg::OFS_RISE: rd_word = {16'h0000, rise_r};
            ssp_pkg::OFS_FALL: rd_word = {16'h0000, fall_r};
            ssp_pkg::OFS_INITIAL: rd_word = {16'h0000, initial_r};
            ssp_pkg::OFS_CEILING: rd_word = {16'h0000, ceil_r};
            ssp_pkg::OFS_FLOOR: rd_word = {16'h0000, floor_r};
            ssp_pkg::OFS_LOAD_SEL: rd_word = {30'h0, load_sel_r};
            ssp_pkg::OFS_STATUS: rd_word = {16'h0000, pot_r};
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        main_sel_nxt = main_sel_r;
        supp_sel_nxt = supp_sel_r;
        cfg_nxt = cfg_r;
        rise_nxt = rise_r;
        fall_nxt = fall_r;
        initial_nxt = initial_r;
        ceil_nxt = ceil_r;
        floor_nxt = floor_r;
        load_sel_nxt = load_sel_r;
        pready_nxt = rd_phase;
        pslverr_nxt = rd_phase & ~hit;
        prdata_nxt = prdata_r;
        if (rd_phase)
            prdata_nxt = (hit && !pwrite_in) ? rd_word : 32'h0000_0000;
        if (wr_en) begin
            unique case (paddr_in)
                ssp_pkg::OFS_MAIN_SEL: main_sel_nxt = pwdata_in[19:0];
                ssp_pkg::OFS_SUPP_SEL: supp_sel_nxt = pwdata_in[19:0];
                ssp_pkg::OFS_CONFIG: cfg_nxt = pwdata_in[4:0];
                ssp_pkg::OFS_RISE: rise_nxt = pwdata_in[15:0];
                ssp_pkg::OFS_FALL: fall_nxt = pwdata_in[15:0];
                ssp_pkg::OFS_INITIAL: initial_nxt = pwdata_in[15:0];
                ssp_pkg::OFS_CEILING: ceil_nxt = pwdata_in[15:0];
                ssp_pkg::OFS_FLOOR: floor_nxt = pwdata_in[15:0];
                ssp_pkg::OFS_LOAD_SEL: load_sel_nxt = pwdata_in[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            main_sel_r <= '0;
            supp_sel_r <= '0;
            cfg_r <= ssp_pkg::CFG_RESET;
            rise_r <= ssp_pkg::RAMP_RESET;
            fall_r <= ssp_pkg::RAMP_RESET;
            initial_r <= ssp_pkg::SPEED_RESET;
            ceil_r <= ssp_pkg::SPEED_RESET;
            floor_r <= ssp_pkg::SPEED_RESET;
            load_sel_r <= ssp_pkg::LOAD_SEL_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            main_sel_r <= main_sel_nxt;
            supp_sel_r <= supp_sel_nxt;
            cfg_r <= cfg_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            initial_r <= initial_nxt;
            ceil_r <= ceil_nxt;
            floor_r <= floor_nxt;
            load_sel_r <= load_sel_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ***********************************************
    // emulated potentiometer
    // ***********************************************
    logic signed [15:0] pot_nxt;
    logic signed [15:0] saved_r, saved_nxt;
    logic [31:0] acc_r, acc_nxt;
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [15:0] round_r, round_nxt;
    logic motor_q_r, strobe_q_r, first_r;
    logic nv_save_r, nv_save_nxt;
    logic signed [15:0] nv_value_r, nv_value_nxt;
    logic tick, run, up, down, on_edge, off_edge, strobe, strobe_edge;
    logic ramp_on;
    logic [15:0] eff_time;
    logic [31:0] gain;
    logic signed [15:0] load_val;
    logic signed [16:0] raw;

    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    assign run = cfg_r.always_run | pulse_en_in;
    assign up = pot_raise_cmd_in & ~pot_lower_cmd_in;
    assign down = pot_lower_cmd_in & ~pot_raise_cmd_in;
    assign on_edge = motor_on_in & ~motor_q_r;
    assign off_edge = ~motor_on_in & motor_q_r;
    assign strobe = load_sel_r[0] & pot_load_strobe_in;
    assign load_val = load_sel_r[1] ? pot_load_value_in : 16'sh0000;
    assign strobe_edge = strobe & ~strobe_q_r;
    // manual mode ignores bit 1, auto mode may bypass the ramp
    assign ramp_on = ~pot_auto_manual_select_in | cfg_r.ramp_auto;
    assign eff_time = ramp_on ? (up ? rise_r : fall_r) : 16'h0000;

    // rate = ceiling per ramp time: ceiling added each ms, one rpm per time
    always_comb begin
        gain = (ceil_r > 16'sh0000) ? {16'h0000, ceil_r} : 32'h0000_0000;
        if (cfg_r.rounding && round_r != ssp_pkg::ROUND_MS)
            gain = gain >> 1;
    end

    always_comb begin
        raw = {pot_r[15], pot_r};
        acc_nxt = acc_r;
        round_nxt = round_r;
        tick_cnt_nxt = tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        saved_nxt = saved_r;
        nv_save_nxt = 1'b0;
        nv_value_nxt = nv_value_r;
        if (first_r && nv_valid_in)
            saved_nxt = nv_value_in;
        if (off_edge) begin
            saved_nxt = pot_r;
            nv_save_nxt = cfg_r.retain & cfg_r.nv_keep;
            nv_value_nxt = pot_r;
        end
        if (on_edge) begin
            raw = cfg_r.retain ? {saved_r[15], saved_r}
                               : {initial_r[15], initial_r};
            acc_nxt = 32'h0000_0000;
        end else if (strobe_edge) begin
            raw = {load_val[15], load_val};
        end else if (run && (up || down)) begin
            if (eff_time == 16'h0000)
                raw = up ? {ceil_r[15], ceil_r} : {floor_r[15], floor_r};
            else if (acc_r >= {16'h0000, eff_time}) begin
                raw = up ? raw + 17'sd1 : raw - 17'sd1;
                acc_nxt = acc_r - {16'h0000, eff_time} + (tick ? gain : 32'h0);
            end else if (tick)
                acc_nxt = acc_r + gain;
            if (tick && round_r != ssp_pkg::ROUND_MS)
                round_nxt = round_r + 16'h0001;
        end else begin
            // idle: rounding restarts with the next command
            acc_nxt = 32'h0000_0000;
            round_nxt = 16'h0000;
        end
        pot_nxt = clamp(raw, floor_r, ceil_r);
        if (!run && !on_edge && !strobe_edge)
            pot_nxt = pot_r;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pot_r <= 16'sh0000;
            saved_r <= 16'sh0000;
            acc_r <= 32'h0000_0000;
            tick_cnt_r <= 32'h0000_0000;
            round_r <= 16'h0000;
            motor_q_r <= 1'b0;
            strobe_q_r <= 1'b0;
            first_r <= 1'b1;
            nv_save_r <= 1'b0;
            nv_value_r <= 16'sh0000;
        end else begin
            pot_r <= pot_nxt;
            saved_r <= saved_nxt;
            acc_r <= acc_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            round_r <= round_nxt;
            motor_q_r <= motor_on_in;
            strobe_q_r <= strobe;
            first_r <= 1'b0;
            nv_save_r <= nv_save_nxt;
            nv_value_r <= nv_value_nxt;
        end
    end

    // ***********************************************
    // setpoint routing
    // ***********************************************
    logic signed [15:0] main_r, main_nxt, supp_r, supp_nxt;
    ssp_pkg::ssp_src_type main_src, supp_src;
    logic ovr_active;

    assign main_src = src_decode(main_sel_r);
    assign supp_src = src_decode(supp_sel_r);
    assign ovr_active = ovr_in.panel | ovr_in.jog |
                        (ovr_in.tech_active & ovr_in.tech_linked);

    // panel beats jog beats technology controller
    always_comb begin
        main_nxt = src_value(main_src, srcs_in, pot_r);
        if (ovr_in.panel)
            main_nxt = ovr_sp_in.panel;
        else if (ovr_in.jog)
            main_nxt = ovr_sp_in.jog;
        else if (ovr_in.tech_active && ovr_in.tech_linked)
            main_nxt = ovr_sp_in.tech;
        supp_nxt = src_value(supp_src, srcs_in, pot_r);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            main_r <= 16'sh0000;
            supp_r <= 16'sh0000;
        end else begin
            main_r <= main_nxt;
            supp_r <= supp_nxt;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign nv_save_out = nv_save_r;
    assign nv_value_out = nv_value_r;
    assign main_setpoint_out = main_r;
    assign supp_setpoint_out = supp_r;
    assign pot_value_out = pot_r;

    // ***********************************************
    // checks
    // ***********************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    logic quiet;
    assign quiet = !on_edge && !strobe_edge && !wr_en && ceil_r >= floor_r;

    cfg_reset_a: assert property ($fell(reset_in) |->
        cfg_r == ssp_pkg::CFG_RESET) else $error("config reset wrong");
    analog_route_a: assert property (
        main_src == ssp_pkg::SRC_ANALOG && !ovr_active |=>
        main_setpoint_out == $past(srcs_in.analog0))
        else $error("analog not routed");
    fieldbus_route_a: assert property (
        supp_src == ssp_pkg::SRC_FIELDBUS |=>
        supp_setpoint_out == $past(srcs_in.fieldbus))
        else $error("process word not routed");
    pot_route_a: assert property (
        main_src == ssp_pkg::SRC_POT && !ovr_active |=>
        main_setpoint_out == $past(pot_r)) else $error("pot not routed");
    jog_override_a: assert property (
        ovr_in.jog && !ovr_in.panel |=>
        main_setpoint_out == $past(ovr_sp_in.jog))
        else $error("jog did not override");
    limit_hold_a: assert property (run && quiet ##1 quiet |->
        pot_r <= ceil_r && pot_r >= floor_r) else $error("pot out of limits");
    ramp_bypass_a: assert property (
        quiet && run && up && pot_auto_manual_select_in && !cfg_r.ramp_auto
        |=> pot_r == $past(ceil_r)) else $error("auto bypass failed");
    manual_step_a: assert property (
        quiet && run && up && !pot_auto_manual_select_in &&
        rise_r != 16'h0000 && pot_r >= floor_r |=>
        pot_r - $past(pot_r) <= 16'sh0001) else $error("manual ramp skipped");
    pulse_gate_a: assert property (
        !cfg_r.always_run && !pulse_en_in && !on_edge && !strobe_edge
        |=> $stable(pot_r)) else $error("pot moved without pulses");
    start_value_a: assert property (
        on_edge && !cfg_r.retain && initial_r <= ceil_r &&
        initial_r >= floor_r |=> pot_r == $past(initial_r))
        else $error("start value not loaded");
    load_edge_a: assert property (
        strobe_edge && !on_edge && run && load_val <= ceil_r &&
        load_val >= floor_r |=> pot_r == $past(load_val))
        else $error("load value not taken");
endmodule
`default_nettype wire

// File: ssp_pkg.sv
`default_nettype none
// ***********************************************
// shared constants and carriers
// ***********************************************
package ssp_pkg;
    localparam int SPD_W = 16;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_MAIN_SEL = 8'h00;
    localparam logic [7:0] OFS_SUPP_SEL = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_RISE = 8'h0C;
    localparam logic [7:0] OFS_FALL = 8'h10;
    localparam logic [7:0] OFS_INITIAL = 8'h14;
    localparam logic [7:0] OFS_CEILING = 8'h18;
    localparam logic [7:0] OFS_FLOOR = 8'h1C;
    localparam logic [7:0] OFS_LOAD_SEL = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    // source codes and indices
    localparam logic [15:0] CODE_ANALOG = 16'h02F3;
    localparam logic [15:0] CODE_FIELDBUS = 16'h0802;
    localparam logic [15:0] CODE_POT = 16'h041A;
    localparam logic [15:0] CODE_FIXED = 16'h0400;
    localparam logic [3:0] IDX_ANALOG = 4'h0;
    localparam logic [3:0] IDX_FIELDBUS = 4'h1;
    // reset values
    localparam logic [4:0] CFG_RESET = 5'h06;
    localparam int RAMP_DEFAULT_MS = 10000;
    localparam logic [15:0] RAMP_RESET = 16'(RAMP_DEFAULT_MS);
    localparam logic [15:0] SPEED_RESET = 16'h0000;
    localparam logic [1:0] LOAD_SEL_RESET = 2'h0;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam logic [15:0] ROUND_MS = 16'h0064;

    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_ANALOG = 3'b001,
        SRC_FIELDBUS = 3'b010,
        SRC_POT = 3'b011,
        SRC_FIXED = 3'b100
    } ssp_src_type;

    typedef struct packed {
        logic [3:0] index;
        logic [15:0] code;
    } ssp_sel_type;

    typedef struct packed {
        logic always_run;
        logic nv_keep;
        logic rounding;
        logic ramp_auto;
        logic retain;
    } ssp_cfg_type;

    typedef struct packed {
        logic signed [15:0] analog0;
        logic signed [15:0] fieldbus;
        logic signed [15:0] fixed;
    } ssp_srcs_type;

    typedef struct packed {
        logic panel;
        logic jog;
        logic tech_active;
        logic tech_linked;
    } ssp_ovr_type;

    typedef struct packed {
        logic signed [15:0] panel;
        logic signed [15:0] jog;
        logic signed [15:0] tech;
    } ssp_ovr_sp_type;
endpackage
`default_nettype wire

// File: ssp_speed_path.sv
`default_nettype none
// ***********************************************
// speed path model: takes the setpoint each cycle
// ***********************************************
module ssp_speed_path (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // setpoint in, speed demand out
    input wire logic signed [15:0] setpoint_in,
    output logic signed [15:0] speed_out
);
    logic signed [15:0] speed_r;
    logic signed [15:0] speed_nxt;
    // no back-pressure: a speed path never refuses a setpoint
    always_comb begin
        speed_nxt = setpoint_in;
    end
    always_ff @(posedge clk_in) begin
        speed_r <= reset_in ? 16'sh0000 : speed_nxt;
    end
    assign speed_out = speed_r;
endmodule
`default_nettype wire

// File: speed_setpoint_source_mop_tb.sv
`default_nettype none
module speed_setpoint_source_mop_tb;
timeunit 1ns;
timeprecision 1ps;
// ***********************************************
// stimulus, checks and verdict
// ***********************************************
logic clk_in, reset_in, psel, penable, pwrite, pready, pslverr;
logic [7:0] paddr;
logic [31:0] pwdata, prdata;
ssp_pkg::ssp_srcs_type srcs;
ssp_pkg::ssp_ovr_type ovr;
ssp_pkg::ssp_ovr_sp_type ovr_sp;
logic raise, lower, auto_sel, strobe, motor_on, pulse_en, nv_save, nv_valid;
logic signed [15:0] load_val, nv_out, main_sp, supp_sp, pot_sp, seen_sp;
logic signed [15:0] nv_val;
int bad_count = 0;
int n_checks = 0;
logic signed [15:0] p;
int n;

ssp_setpoint_source #(.TICK_CYCLES(10)) uut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .srcs_in(srcs), .ovr_in(ovr),
    .ovr_sp_in(ovr_sp), .pot_raise_cmd_in(raise),
    .pot_lower_cmd_in(lower), .pot_auto_manual_select_in(auto_sel),
    .pot_load_strobe_in(strobe), .pot_load_value_in(load_val),
    .motor_on_in(motor_on), .pulse_en_in(pulse_en),
    .nv_valid_in(nv_valid), .nv_value_in(nv_val),
    .nv_save_out(nv_save), .nv_value_out(nv_out),
    .main_setpoint_out(main_sp), .supp_setpoint_out(supp_sp),
    .pot_value_out(pot_sp));

ssp_speed_path partner (.clk_in(clk_in), .reset_in(reset_in),
    .setpoint_in(main_sp), .speed_out(seen_sp));

initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
end

task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        bad_count++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

// one psel-low cycle between transfers keeps each driver edge single
task automatic apb(input logic w, input logic [7:0] a,
                   input logic [31:0] d, output logic [31:0] q,
                   output logic e);
    int k;
    k = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) begin
        k++;
        if (k > 50) begin
            bad_count++;
            print_verdict();
        end
        @(posedge clk_in);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
endtask

task automatic rd(input logic [7:0] a, input logic [31:0] x,
                  input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
    check(32'(e), 32'(xe));
endtask

task automatic cyc(input int c);
    repeat (c) @(posedge clk_in);
endtask

task automatic in_range(input int lo, input int hi);
    check(32'(pot_sp > lo && pot_sp < hi), 32'h1);
endtask

// index 1 on the analog code is a wrong pairing and must give zero
function automatic logic [31:0] sel_word(input int k);
    case (k % 4)
        0: sel_word = {12'h000, ssp_pkg::IDX_ANALOG, ssp_pkg::CODE_ANALOG};
        1: sel_word = {12'h000, ssp_pkg::IDX_FIELDBUS,
                       ssp_pkg::CODE_FIELDBUS};
        2: sel_word = {12'h000, 4'(k), ssp_pkg::CODE_FIXED};
        default: sel_word = {12'h000, 4'h1, ssp_pkg::CODE_ANALOG};
    endcase
endfunction

function automatic logic signed [15:0] exp_src(input int k);
    case (k % 4)
        0: exp_src = srcs.analog0;
        1: exp_src = srcs.fieldbus;
        2: exp_src = srcs.fixed;
        default: exp_src = 16'sh0000;
    endcase
endfunction

function automatic logic signed [15:0] exp_ovr();
    if (ovr.panel) exp_ovr = ovr_sp.panel;
    else if (ovr.jog) exp_ovr = ovr_sp.jog;
    else if (ovr.tech_active && ovr.tech_linked) exp_ovr = ovr_sp.tech;
    else exp_ovr = srcs.analog0;
endfunction

initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {srcs, ovr, ovr_sp, raise, lower, auto_sel, strobe} = '0;
    {load_val, motor_on, nv_valid, nv_val} = '0;
    pulse_en = 1'b1;
    reset_in = 1'b1;
    void'($urandom(17));
    cyc(20);
    reset_in <= 1'b0;
    rd(ssp_pkg::OFS_CONFIG, 32'h6, 1'b0);
    rd(ssp_pkg::OFS_RISE, 32'h2710, 1'b0);
    rd(ssp_pkg::OFS_FALL, 32'h2710, 1'b0);
    rd(ssp_pkg::OFS_INITIAL, 32'h0, 1'b0);
    rd(ssp_pkg::OFS_CEILING, 32'h0, 1'b0);
    rd(ssp_pkg::OFS_FLOOR, 32'h0, 1'b0);
    rd(ssp_pkg::OFS_LOAD_SEL, 32'h0, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
        srcs <= 48'({$urandom, $urandom});
        wr(ssp_pkg::OFS_MAIN_SEL, sel_word(i));
        wr(ssp_pkg::OFS_SUPP_SEL, sel_word(i + 1));
        cyc(2);
        check(32'(main_sp), 32'(exp_src(i)));
        check(32'(supp_sp), 32'(exp_src(i + 1)));
    end
    wr(ssp_pkg::OFS_MAIN_SEL, sel_word(0));
    for (int i = 0; i < 16; i++) begin
        ovr <= 4'(i);
        ovr_sp <= 48'({$urandom, $urandom});
        cyc(2);
        check(32'(main_sp), 32'(exp_ovr()));
    end
    ovr <= '0;
    wr(ssp_pkg::OFS_CONFIG, 32'h0);
    wr(ssp_pkg::OFS_CEILING, 32'h64);
    wr(ssp_pkg::OFS_RISE, 32'hA);
    wr(ssp_pkg::OFS_FALL, 32'hA);
    wr(ssp_pkg::OFS_LOAD_SEL, 32'h3);
    wr(ssp_pkg::OFS_MAIN_SEL, {16'h0000, ssp_pkg::CODE_POT});
    motor_on <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'h0);
    // auto mode without ramp: jump to the limits
    auto_sel <= 1'b1;
    raise <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'h64);
    raise <= 1'b0;
    lower <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'h0);
    lower <= 1'b0;
    auto_sel <= 1'b0;
    // manual: 100 rpm over 10 ms is about one rpm per cycle here
    raise <= 1'b1;
    cyc(55);
    in_range(40, 60);
    cyc(100);
    check(32'(pot_sp), 32'h64);
    raise <= 1'b0;
    lower <= 1'b1;
    cyc(30);
    in_range(60, 80);
    lower <= 1'b0;
    pulse_en <= 1'b0;
    cyc(1);
    p = pot_sp;
    raise <= 1'b1;
    cyc(30);
    check(32'(pot_sp), 32'(p));
    wr(ssp_pkg::OFS_CONFIG, 32'h10);
    cyc(20);
    check(32'(pot_sp > p), 32'h1);
    raise <= 1'b0;
    pulse_en <= 1'b1;
    wr(ssp_pkg::OFS_CONFIG, 32'h0);
    p = 16'($urandom_range(99));
    load_val <= p;
    strobe <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'(p));
    strobe <= 1'b0;
    load_val <= 16'sh01F4;
    cyc(1);
    strobe <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'h64);
    strobe <= 1'b0;
    check(32'(main_sp), 32'h64);
    cyc(1);
    check(32'(seen_sp), 32'h64);
    wr(ssp_pkg::OFS_INITIAL, 32'h14);
    motor_on <= 1'b0;
    cyc(2);
    motor_on <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'h14);
    wr(ssp_pkg::OFS_CONFIG, 32'h9);
    load_val <= 16'sh0037;
    strobe <= 1'b1;
    cyc(2);
    strobe <= 1'b0;
    motor_on <= 1'b0;
    for (n = 0; n < 10 && nv_save !== 1'b1; n++) @(posedge clk_in);
    check(32'(nv_save), 32'h1);
    check(32'(nv_out), 32'h37);
    load_val <= 16'sh000A;
    strobe <= 1'b1;
    cyc(2);
    motor_on <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'h37);
    // rounding halves the rate at the start of a ramp
    strobe <= 1'b0;
    load_val <= 16'sh0000;
    cyc(1);
    strobe <= 1'b1;
    wr(ssp_pkg::OFS_CONFIG, 32'h4);
    raise <= 1'b1;
    cyc(45);
    in_range(15, 30);
    // power loss: stored value comes back at the next switch-on
    raise <= 1'b0;
    strobe <= 1'b0;
    motor_on <= 1'b0;
    p = 16'($urandom_range(99));
    nv_val <= p;
    nv_valid <= 1'b1;
    reset_in <= 1'b1;
    cyc(2);
    reset_in <= 1'b0;
    rd(ssp_pkg::OFS_CONFIG, 32'h6, 1'b0);
    wr(ssp_pkg::OFS_CONFIG, 32'h9);
    wr(ssp_pkg::OFS_CEILING, 32'h64);
    motor_on <= 1'b1;
    cyc(3);
    check(32'(pot_sp), 32'(p));
    print_verdict();
end
endmodule
`default_nettype wire
